// ===== pkg/pwm_fault_pkg.sv
// register map, field layout and reset values of the fault, override and duty block
package pwm_fault_pkg;
	localparam logic [7:0] fault_a_control_off = 8'h00;
	localparam logic [7:0] fault_b_control_off = 8'h04;
	localparam logic [7:0] output_override_control_off = 8'h08;
	localparam logic [7:0] duty_cycle_one_off = 8'h0C;
	localparam logic [7:0] duty_cycle_two_off = 8'h10;
	localparam logic [7:0] duty_cycle_three_off = 8'h14;
	localparam logic [7:0] pwm_control_off = 8'h18;
	localparam logic [7:0] unlock_key_register_off = 8'h1C;
	localparam logic [7:0] status_off = 8'h20;
	localparam int fault_override_lsb = 8;
	localparam int fault_mode_bit = 7;
	localparam int override_enable_lsb = 8;
	localparam int override_sync_bit = 1;
	localparam int immediate_duty_bit = 2;
	localparam int latch_clear_a_bit = 8;
	localparam int latch_clear_b_bit = 9;
	localparam logic [15:0] fault_control_mask = 16'h3F87;
	localparam logic [15:0] override_mask = 16'h3F3F;
	localparam logic [15:0] pwm_control_mask = 16'h0006;
	localparam logic [15:0] fault_control_reset = 16'h0007;
	localparam logic [15:0] override_reset = 16'h3F00;
	localparam logic [15:0] duty_reset = 16'h0000;
	localparam logic [15:0] unlock_key_first = 16'hA5A5;
	localparam logic [15:0] unlock_key_second = 16'h5A5A;
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;
	typedef enum logic [1:0] {
		key_idle = 2'b00,
		key_first = 2'b01,
		key_open = 2'b11
	} key_state_t;
endpackage

// ===== rtl/pwm_fault_override_duty.sv
// fault override, manual override and duty registers of a three-pair pwm unit
// How it works
// - while fault a is held for an enabled pair each pin of that pair takes its fault-a value.
// - fault a mode 1 runs cycle by cycle, mode 0 latches the fault-a override on an event.
// - three fault-a enables pick which pairs fault a controls, all set after reset.
// - while fault b is held for an enabled pair each pin of that pair takes its fault-b value.
// - fault b mode 1 runs cycle by cycle, mode 0 latches the fault-b override on an event.
// - three fault-b enables pick which pairs fault b controls, all set after reset.
// - with the lock strap set, writes to the fault a control register are dropped unless the unlock is done.
// - fault a comes out of any reset enabled and software must clear it when unused.
// - fault b comes out of any reset enabled and software must clear it when unused.
// - fault events come only from the two dedicated fault pins.
// - an override-enable bit of 1 hands the pin to the pwm generator, 0 to the manual bit.
// - a cleared override-enable lets the manual bit drive the pin; manual bits reset to 0.
// - three independent 16-bit duty values are readable, writable and reset to zero.
// - with override sync set, override changes apply at the period boundary, else next cycle.
// - with immediate update set, duty writes apply at once, else at the period boundary.
// - with the lock strap set both fault registers need the key sequence before a write.
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pwm_fault_override_duty
	import pwm_fault_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fault_input_a_pin,
	input wire logic fault_input_b_pin,
	input wire logic write_lock_config,
	input wire logic period_boundary,
	input wire logic [5:0] pwm_gen_out,
	output logic [2:0] high_side_output,
	output logic [2:0] low_side_output,
	output logic [15:0] duty_value_one,
	output logic [15:0] duty_value_two,
	output logic [15:0] duty_value_three
);
	function automatic logic [5:0] pair_mask(input logic [2:0] en);
		pair_mask = {en[2], en[2], en[1], en[1], en[0], en[0]};
	endfunction

	logic [15:0] fault_a_control_ff, fault_b_control_ff, override_ff, active_override_ff;
	logic [15:0] pwm_control_ff, duty_buf_ff [3], duty_act_ff [3];
	logic [1:0] sync_a_ff, sync_b_ff;
	logic latch_a_ff, latch_b_ff, cyc_a_ff, cyc_b_ff;
	logic lock_strap_ff, strap_taken_ff;
	key_state_t key_ff, nxt_key;
	logic aw_have_ff, w_have_ff;
	logic [7:0] aw_addr_ff;
	logic aw_high_ff;
	logic [15:0] w_data_ff;
	logic [1:0] w_strb_ff;
	logic [5:0] pins_ff;

	// two flip-flops on each fault pin; no other source feeds the fault logic
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_a_ff <= 2'b00;
			sync_b_ff <= 2'b00;
		end else begin
			sync_a_ff <= {sync_a_ff[0], fault_input_a_pin};
			sync_b_ff <= {sync_b_ff[0], fault_input_b_pin};
		end
	end
	wire fault_a = sync_a_ff[1];
	wire fault_b = sync_b_ff[1];

	// lock strap caught after reset release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_taken_ff <= 1'b0;
			lock_strap_ff <= 1'b1;
		end else if (!strap_taken_ff) begin
			strap_taken_ff <= 1'b1;
			lock_strap_ff <= write_lock_config;
		end
	end

	// bus write capture
	wire do_write = aw_have_ff && w_have_ff && !s_axi_bvalid;
	wire [15:0] wr_mask = {{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
	wire hit_fa = do_write && aw_addr_ff == fault_a_control_off;
	wire hit_fb = do_write && aw_addr_ff == fault_b_control_off;
	wire hit_ov = do_write && aw_addr_ff == output_override_control_off;
	wire hit_d1 = do_write && aw_addr_ff == duty_cycle_one_off;
	wire hit_d2 = do_write && aw_addr_ff == duty_cycle_two_off;
	wire hit_d3 = do_write && aw_addr_ff == duty_cycle_three_off;
	wire hit_pc = do_write && aw_addr_ff == pwm_control_off;
	wire hit_key = do_write && aw_addr_ff == unlock_key_register_off;
	wire hit_st = do_write && aw_addr_ff == status_off;
	wire wr_known = hit_fa | hit_fb | hit_ov | hit_d1 | hit_d2 | hit_d3 | hit_pc | hit_key | hit_st;
	wire unlocked = !lock_strap_ff || key_ff == key_open;
	wire fa_write = hit_fa && unlocked;
	wire fb_write = hit_fb && unlocked;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] mask);
		merge = ((old & ~wr_mask) | (w_data_ff & wr_mask)) & mask;
	endfunction

	// unlock sequence: two key words, then one fault register write
	always_comb begin
		nxt_key = key_ff;
		if (hit_key && w_data_ff == unlock_key_first)
			nxt_key = key_first;
		else if (hit_key && key_ff == key_first && w_data_ff == unlock_key_second)
			nxt_key = key_open;
		else if (hit_key || ((hit_fa || hit_fb) && key_ff == key_open))
			nxt_key = key_idle;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			key_ff <= key_idle;
		end else begin
			key_ff <= nxt_key;
		end
	end

	// registers; fault enables and override enables come out of reset set
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_a_control_ff <= fault_control_reset;
			fault_b_control_ff <= fault_control_reset;
			override_ff <= override_reset;
			pwm_control_ff <= duty_reset;
		end else begin
			if (fa_write)
				fault_a_control_ff <= merge(fault_a_control_ff, fault_control_mask);
			if (fb_write)
				fault_b_control_ff <= merge(fault_b_control_ff, fault_control_mask);
			if (hit_ov)
				override_ff <= merge(override_ff, override_mask);
			if (hit_pc)
				pwm_control_ff <= merge(pwm_control_ff, pwm_control_mask);
		end
	end

	// duty buffers and active values
	wire imm = pwm_control_ff[immediate_duty_bit];
	wire [2:0] hit_d = {hit_d3, hit_d2, hit_d1};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 3; i++) begin
				duty_buf_ff[i] <= duty_reset;
				duty_act_ff[i] <= duty_reset;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (hit_d[i])
					duty_buf_ff[i] <= merge(duty_buf_ff[i], 16'hFFFF);
				if (imm && hit_d[i])
					duty_act_ff[i] <= merge(duty_buf_ff[i], 16'hFFFF);
				else if (period_boundary)
					duty_act_ff[i] <= duty_buf_ff[i];
			end
		end
	end

	// override register takes effect now or at the period boundary
	wire override_sync_select = pwm_control_ff[override_sync_bit];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			active_override_ff <= override_reset;
		end else if (!override_sync_select || period_boundary) begin
			active_override_ff <= override_ff;
		end
	end

	// fault state: latched holds until software clears, cycle mode waits for boundary
	wire [15:0] st_wmask = hit_st ? (w_data_ff & wr_mask) : 16'h0000;
	wire clr_a = st_wmask[latch_clear_a_bit];
	wire clr_b = st_wmask[latch_clear_b_bit];
	wire mode_a = fault_a_control_ff[fault_mode_bit];
	wire mode_b = fault_b_control_ff[fault_mode_bit];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latch_a_ff <= 1'b0;
			latch_b_ff <= 1'b0;
			cyc_a_ff <= 1'b0;
			cyc_b_ff <= 1'b0;
		end else begin
			// set wins over the software clear
			latch_a_ff <= (fault_a && !mode_a) || (latch_a_ff && !clr_a);
			latch_b_ff <= (fault_b && !mode_b) || (latch_b_ff && !clr_b);
			cyc_a_ff <= (fault_a && mode_a) || (cyc_a_ff && !period_boundary);
			cyc_b_ff <= (fault_b && mode_b) || (cyc_b_ff && !period_boundary);
		end
	end

	wire act_a = fault_a || latch_a_ff || cyc_a_ff;
	wire act_b = fault_b || latch_b_ff || cyc_b_ff;
	wire [5:0] sel_a = act_a ? pair_mask(fault_a_control_ff[2:0]) : 6'b000000;
	wire [5:0] sel_b = act_b ? pair_mask(fault_b_control_ff[2:0]) : 6'b000000;
	wire [5:0] ov_en = active_override_ff[override_enable_lsb +: 6];
	wire [5:0] manual = active_override_ff[5:0];
	wire [5:0] base = (ov_en & pwm_gen_out) | (~ov_en & manual);
	wire [5:0] fval_a = fault_a_control_ff[fault_override_lsb +: 6];
	wire [5:0] fval_b = fault_b_control_ff[fault_override_lsb +: 6];
	wire [5:0] after_b = (sel_b & fval_b) | (~sel_b & base);
	// fault a outranks fault b
	wire [5:0] nxt_pins = (sel_a & fval_a) | (~sel_a & after_b);

	// pin order per pair: bit 2k+1 high side, bit 2k low side
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pins_ff <= 6'b000000;
		end else begin
			pins_ff <= nxt_pins;
		end
	end
	assign high_side_output = {pins_ff[5], pins_ff[3], pins_ff[1]};
	assign low_side_output = {pins_ff[4], pins_ff[2], pins_ff[0]};
	assign duty_value_one = duty_act_ff[0];
	assign duty_value_two = duty_act_ff[1];
	assign duty_value_three = duty_act_ff[2];

	// axi write channel; ready flops stay low while a beat is held or the answer waits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			aw_high_ff <= 1'b0;
			w_data_ff <= 16'h0000;
			w_strb_ff <= 2'b00;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr[7:0];
				aw_high_ff <= |s_axi_awaddr[31:8];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_ff <= 1'b1;
				w_data_ff <= s_axi_wdata[15:0];
				w_strb_ff <= s_axi_wstrb[1:0];
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have_ff <= 1'b0;
				w_have_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_known && !aw_high_ff) ? resp_okay : resp_slverr;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// axi read channel
	logic [15:0] rd_val;
	logic rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		unique case (s_axi_araddr[7:0])
			fault_a_control_off: rd_val = fault_a_control_ff;
			fault_b_control_off: rd_val = fault_b_control_ff;
			output_override_control_off: rd_val = override_ff;
			duty_cycle_one_off: rd_val = duty_buf_ff[0];
			duty_cycle_two_off: rd_val = duty_buf_ff[1];
			duty_cycle_three_off: rd_val = duty_buf_ff[2];
			pwm_control_off: rd_val = pwm_control_ff;
			unlock_key_register_off: rd_val = {14'h0000, key_ff};
			status_off: rd_val = {6'h00, latch_b_ff, latch_a_ff, 2'b00, cyc_b_ff, cyc_a_ff,
				fault_b, fault_a, act_b, act_a};
			default: begin
				rd_val = 16'h0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= resp_okay;
			s_axi_arready <= 1'b1;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {16'h0000, rd_val};
			s_axi_rresp <= rd_ok ? resp_okay : resp_slverr;
			s_axi_arready <= 1'b0;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	a_fault_a_force: assert property (@(posedge clk) disable iff (rst)
		(fault_a && fault_a_control_ff[0]) |=> pins_ff[1:0] == $past(fval_a[1:0]))
		else $error("fault a did not force pair one");
	a_fault_b_force: assert property (@(posedge clk) disable iff (rst)
		(fault_b && !act_a && fault_b_control_ff[2]) |=> pins_ff[5:4] == $past(fval_b[5:4]))
		else $error("fault b did not force pair three");
	a_latch_holds: assert property (@(posedge clk) disable iff (rst)
		(latch_a_ff && !clr_a) |=> latch_a_ff)
		else $error("latched fault a released without clear");
	a_cycle_release: assert property (@(posedge clk) disable iff (rst)
		(cyc_b_ff && !fault_b && period_boundary) |=> !cyc_b_ff)
		else $error("cycle fault b not released at boundary");
	a_lock_blocks: assert property (@(posedge clk) disable iff (rst)
		(hit_fa && !unlocked) |=> $stable(fault_a_control_ff))
		else $error("locked fault a register was written");
	a_manual_drive: assert property (@(posedge clk) disable iff (rst)
		(!act_a && !act_b && !ov_en[0]) |=> pins_ff[0] == $past(manual[0]))
		else $error("manual bit did not drive pin");
	a_duty_sync: assert property (@(posedge clk) disable iff (rst)
		(!imm && !period_boundary) |=> $stable(duty_act_ff[1]))
		else $error("duty changed off boundary");
	a_override_sync: assert property (@(posedge clk) disable iff (rst)
		(override_sync_select && !period_boundary) |=> $stable(active_override_ff))
		else $error("override changed off boundary");
	a_fault_source: assert property (@(posedge clk) disable iff (rst)
		$rose(fault_a) |-> $past(fault_input_a_pin, 2))
		else $error("fault a without pin");
	a_duty_write: assert property (@(posedge clk) disable iff (rst)
		(hit_d2 && wr_mask == 16'hFFFF) |=> duty_buf_ff[1] == $past(w_data_ff))
		else $error("duty two write lost");
	c_latch_a: cover property (@(posedge clk) disable iff (rst) $rose(latch_a_ff));
	c_cycle_b: cover property (@(posedge clk) disable iff (rst) $fell(cyc_b_ff));
	c_unlock: cover property (@(posedge clk) disable iff (rst) fa_write && lock_strap_ff);
	c_manual: cover property (@(posedge clk) disable iff (rst) ov_en != 6'b111111);
endmodule
`default_nettype wire

// ===== testbench/pwm_far_side.sv
// far side model: fault sources, time base pulse and generator outputs
`timescale 1ns/1ps
`default_nettype none
module pwm_far_side (
	input wire logic clk,
	input wire logic rst,
	input wire logic fault_a_req,
	input wire logic fault_b_req,
	input wire logic bound_req,
	input wire logic [5:0] gen_req,
	output logic fault_input_a_pin,
	output logic fault_input_b_pin,
	output logic period_boundary,
	output logic [5:0] pwm_gen_out
);
	// faults reach the block only through the two dedicated pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_input_a_pin <= 1'h0;
			fault_input_b_pin <= 1'h0;
			period_boundary <= 1'h0;
			pwm_gen_out <= 6'h00;
		end else begin
			fault_input_a_pin <= fault_a_req;
			fault_input_b_pin <= fault_b_req;
			period_boundary <= bound_req;
			pwm_gen_out <= gen_req;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/pwm_fault_override_duty_tb.sv
// self-checking bench of the fault, override and duty block
`timescale 1ns/1ps
`default_nettype none
module pwm_fault_override_duty_tb;
	import pwm_fault_pkg::*;
	logic clk = 1'h0, rst = 1'h1, write_lock_config = 1'h1;
	logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000;
	logic [31:0] s_axi_araddr = 32'h0000_0000;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic fault_a_req = 1'h0, fault_b_req = 1'h0, bound_req = 1'h0;
	logic [5:0] gen_req = 6'h00;
	logic [15:0] rnd = 16'h589d;
	logic [33:0] expq[$];
	logic [1:0] expb[$];
	int failures = 0, checks_done = 0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic fault_input_a_pin, fault_input_b_pin, period_boundary;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [5:0] pwm_gen_out, pins;
	wire logic [2:0] high_side_output, low_side_output;
	wire logic [15:0] duty_value_one, duty_value_two, duty_value_three;
	assign pins = {high_side_output[2], low_side_output[2], high_side_output[1],
		low_side_output[1], high_side_output[0], low_side_output[0]};
	pwm_far_side i_pwm_far_side (.clk, .rst, .fault_a_req, .fault_b_req, .bound_req, .gen_req,
		.fault_input_a_pin, .fault_input_b_pin, .period_boundary, .pwm_gen_out);
	pwm_fault_override_duty i_pwm_fault_override_duty (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fault_input_a_pin, .fault_input_b_pin,
		.write_lock_config, .period_boundary, .pwm_gen_out, .high_side_output, .low_side_output,
		.duty_value_one, .duty_value_two, .duty_value_three);
	always #4 clk = ~clk;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk_rd(input logic [33:0] e, input logic [33:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic chk_out(input logic [15:0] e, input logic [15:0] g);
		chk_rd({18'h0_0000, e}, {18'h0_0000, g});
	endtask
	task automatic chk_wr(input logic [1:0] e, input logic [1:0] g);
		chk_rd({32'h0000_0000, e}, {32'h0000_0000, g});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic newgen();
		rnd = lfsr(rnd);
		gen_req <= rnd[5:0];
	endtask
	task automatic bnd();
		bound_req <= 1'h1;
		@(posedge clk);
		bound_req <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic ta, tw;
		ta = 1'h0;
		tw = 1'h0;
		s_axi_awaddr <= {24'h00_0000, a};
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		expb.push_back((a[1:0] == 2'b00 && a <= status_off) ? resp_okay : resp_slverr);
		while (!(ta && tw)) begin
			@(negedge clk);
			ta = ta || (s_axi_awvalid && s_axi_awready);
			tw = tw || (s_axi_wvalid && s_axi_wready);
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
		end
		do @(negedge clk); while (!s_axi_bvalid);
		@(posedge clk);
	endtask
	task automatic wrk(input logic [7:0] a, input logic [15:0] d);
		wr(unlock_key_register_off, unlock_key_first);
		wr(unlock_key_register_off, unlock_key_second);
		wr(a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [15:0] d);
		expq.push_back({r, 16'h0000, d});
		s_axi_araddr <= {24'h00_0000, a};
		s_axi_arvalid <= 1'h1;
		do @(negedge clk); while (!s_axi_arready);
		@(posedge clk);
		s_axi_arvalid <= 1'h0;
		do @(negedge clk); while (!s_axi_rvalid);
		@(posedge clk);
	endtask
	task automatic results();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// read answers are matched against the oldest noted expectation
	always @(posedge clk) begin
		if (s_axi_rvalid && s_axi_rready) chk_rd(expq.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready) chk_wr(expb.pop_front(), s_axi_bresp);
	end
	initial begin
		#60000;
		failures++;
		results();
	end
	initial begin
		cyc(5);
		rst <= 1'h0;
		cyc(1);
		rd(fault_a_control_off, resp_okay, 16'h0007);
		rd(fault_b_control_off, resp_okay, 16'h0007);
		rd(output_override_control_off, resp_okay, 16'h3f00);
		rd(duty_cycle_one_off, resp_okay, 16'h0000);
		rd(duty_cycle_two_off, resp_okay, 16'h0000);
		rd(duty_cycle_three_off, resp_okay, 16'h0000);
		rd(8'h24, resp_slverr, 16'h0000);
		wr(8'h24, 16'h1234);
		$display("test reset values done");
		newgen();
		cyc(4);
		chk_out(16'(gen_req), 16'(pins));
		fault_a_req <= 1'h1;
		cyc(6);
		chk_out(16'h0000, 16'(pins));
		fault_a_req <= 1'h0;
		cyc(6);
		bnd();
		cyc(6);
		chk_out(16'h0000, 16'(pins));
		wr(status_off, 16'h0100);
		cyc(6);
		chk_out(16'(gen_req), 16'(pins));
		$display("test latched fault done");
		wr(fault_a_control_off, 16'h2a82);
		rd(fault_a_control_off, resp_okay, 16'h0007);
		wrk(fault_a_control_off, 16'h2a82);
		rd(fault_a_control_off, resp_okay, 16'h2a82);
		wrk(fault_b_control_off, 16'hc000);
		rd(fault_b_control_off, resp_okay, 16'h0000);
		$display("test write lock done");
		for (int i = 0; i < 2; i++) begin
			newgen();
			fault_a_req <= 1'h1;
			cyc(6);
			chk_out(16'((gen_req & 6'h33) | 6'h08), 16'(pins));
			fault_a_req <= 1'h0;
			cyc(6);
			chk_out(16'((gen_req & 6'h33) | 6'h08), 16'(pins));
			bnd();
			cyc(6);
			chk_out(16'(gen_req), 16'(pins));
		end
		$display("test cycle fault a done");
		wrk(fault_a_control_off, 16'h2a80);
		wrk(fault_b_control_off, 16'h1581);
		newgen();
		fault_a_req <= 1'h1;
		fault_b_req <= 1'h1;
		cyc(6);
		chk_out(16'((gen_req & 6'h3c) | 6'h01), 16'(pins));
		fault_a_req <= 1'h0;
		fault_b_req <= 1'h0;
		cyc(6);
		bnd();
		cyc(6);
		chk_out(16'(gen_req), 16'(pins));
		$display("test fault b done");
		wr(pwm_control_off, 16'h0002);
		wr(output_override_control_off, 16'h0015);
		cyc(4);
		chk_out(16'(gen_req), 16'(pins));
		bnd();
		cyc(4);
		chk_out(16'h0015, 16'(pins));
		wr(pwm_control_off, 16'h0004);
		wr(output_override_control_off, 16'h3f00);
		cyc(4);
		chk_out(16'(gen_req), 16'(pins));
		$display("test manual override done");
		rnd = lfsr(rnd);
		wr(duty_cycle_two_off, rnd);
		cyc(2);
		chk_out(rnd, duty_value_two);
		wr(pwm_control_off, 16'h0000);
		wr(duty_cycle_one_off, ~rnd);
		wr(duty_cycle_three_off, 16'hffff);
		rd(duty_cycle_one_off, resp_okay, ~rnd);
		chk_out(16'h0000, duty_value_one);
		bnd();
		cyc(4);
		chk_out(~rnd, duty_value_one);
		chk_out(16'hffff, duty_value_three);
		chk_out(rnd, duty_value_two);
		$display("test duty values done");
		write_lock_config <= 1'h0;
		rst <= 1'h1;
		cyc(2);
		rst <= 1'h0;
		cyc(1);
		chk_out(16'h0000, duty_value_two);
		rd(fault_a_control_off, resp_okay, 16'h0007);
		wr(fault_b_control_off, 16'h2a05);
		rd(fault_b_control_off, resp_okay, 16'h2a05);
		newgen();
		fault_b_req <= 1'h1;
		cyc(6);
		chk_out(16'((gen_req & 6'h0c) | 6'h22), 16'(pins));
		fault_b_req <= 1'h0;
		cyc(6);
		bnd();
		cyc(6);
		chk_out(16'((gen_req & 6'h0c) | 6'h22), 16'(pins));
		wr(status_off, 16'h0200);
		cyc(6);
		chk_out(16'(gen_req), 16'(pins));
		$display("test reset without lock done");
		results();
	end
endmodule
`default_nettype wire
